//--- design/ssm_pkg.sv
/*
 * Shared constants and types for the successive-approximation sequencer
 * and its serial-master readout, used by both ends of the link.
 * Assumes a 200 MHz core clock on both ends; times are converted to cycles here.
 */
package ssm_pkg;

    // Result width and the decision that carries the error correction.
    localparam int RESULT_BITS   = 12;
    localparam int CORR_DECISION = 10;

    // Core clock period.
    localparam int CLK_PERIOD_NS = 5;

    // One bit decision; the tenth one then lands 10.5 us into the conversion.
    localparam int DECISION_NS  = 1050;
    localparam int DECISION_CYC = DECISION_NS / CLK_PERIOD_NS;
    // The correction check takes the first half of the tenth decision.
    localparam int CHECK_CYC    = DECISION_CYC / 2;

    // Quarter of a serial bit: least setup and hold around each clock edge.
    localparam int SCLK_QUARTER_NS  = 150;
    localparam int SCLK_QUARTER_CYC = (SCLK_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Host side: least low time of the start strobe, and the wait for busy.
    localparam int START_LOW_NS   = 100;
    localparam int START_LOW_CYC  = (START_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUSY_WAIT_NS   = 2000;
    localparam int BUSY_WAIT_CYC  = BUSY_WAIT_NS / CLK_PERIOD_NS;

    // Values after reset.
    localparam logic [RESULT_BITS-1:0] RESULT_RST = 12'h000;
    localparam logic                   MASTER_SEL = 1'b0;

    typedef enum logic [1:0] {
        DEV_IDLE = 2'b01,
        DEV_CONVERSION_START_N = 2'b10
    } ssm_dev_state_t;

    typedef enum logic [3:0] {
        HOST_IDLE      = 4'b0001,
        HOST_PULSE     = 4'b0010,
        HOST_WAIT_LOW  = 4'b0100,
        HOST_WAIT_HIGH = 4'b1000
    } ssm_host_state_t;

endpackage

//--- design/ssm_link_if.sv
/*
 * Pins between the converter sequencer and the host acting as serial slave.
 * Assumes the converter drives the serial clock; no wire here is shared or three-state.
 */
`timescale 1ns/1ps
`default_nettype none

interface ssm_link_if;
    logic conversion_start_n;   // Active-low start, host to converter.
    logic clock_source_select;  // Low selects internal serial clock.
    logic busy;                 // Low while converting; host slave select.
    logic serial_clock;         // Serial clock made by the converter.
    logic serial_result_out;    // Result bits, most significant first.

    modport dev (
        input  conversion_start_n,
        input  clock_source_select,
        output busy,
        output serial_clock,
        output serial_result_out
    );

    modport host (
        output conversion_start_n,
        output clock_source_select,
        input  busy,
        input  serial_clock,
        input  serial_result_out
    );
endinterface

`default_nettype wire

//--- design/ssm_sar_device.sv
/*
 * Converter end: sequences the bit decisions of one conversion and, in
 * master mode, shifts the previous result out on its own serial clock.
 * Assumes an external comparator answers i_cmp_high within one decision
 * period for the value shown on o_trial, and that the host keeps the
 * start and mode pins quiet late in a conversion.
 */
// Function
// - Twelve decisions per conversion, most significant first.
// - Trial value is resolved bits plus tested bit.
// - Clear tested bit when trial exceeds input.
// - Tenth decision corrects earlier errors, later none.
// - Tenth decision about 10 to 11 us in.
// - Host keeps inputs static late in conversion.
// - Host may raise start anytime, early preferred.
// - Select low makes converter serial master.
// - Busy is low during a conversion.
// - Busy falling starts shifting previous result.
// - Serial clock idles low, data stable both edges.
// - Host slave select is tied to busy.
// - Host is sole 12-bit serial slave.
`timescale 1ns/1ps
`default_nettype none

module ssm_sar_device #(
    parameter int WIDTH     = ssm_pkg::RESULT_BITS,       // Result width.
    parameter int DEC_CYC   = ssm_pkg::DECISION_CYC,      // Cycles per decision.
    parameter int CHECK_CYC = ssm_pkg::CHECK_CYC,         // Correction check cycles.
    parameter int QTR_CYC   = ssm_pkg::SCLK_QUARTER_CYC   // Serial quarter bit cycles.
) (
    input  wire logic             i_clock,         // Internal core clock.
    input  wire logic             i_rst,           // Synchronous reset, high.
    ssm_link_if.dev               lnk,             // Pins toward the host.
    output logic [WIDTH-1:0]      o_trial,         // Trial value for comparator.
    input  wire logic             i_cmp_high,      // Trial exceeds sampled input.
    output logic [WIDTH-1:0]      o_result,        // Last finished result.
    output logic                  o_result_valid   // Pulse when a result lands.
);

    localparam int IW = $clog2(WIDTH);
    localparam int TW = $clog2(DEC_CYC + 1);
    localparam int QW = $clog2(QTR_CYC + 1);
    localparam logic [IW-1:0] LAST_IDX = IW'(WIDTH - 1);
    localparam logic [IW-1:0] CORR_IDX = IW'(ssm_pkg::CORR_DECISION - 1);

    // One-hot mask of the bit tested in decision idx, counted from the MSB.
    function automatic logic [WIDTH-1:0] bit_of(input logic [IW-1:0] idx);
        logic [WIDTH-1:0] one;
        one    = WIDTH'(1);
        bit_of = one << (LAST_IDX - idx);
    endfunction

    // Saturating add, so a correction never wraps a near-full code to zero.
    function automatic logic [WIDTH-1:0] sat_add(input logic [WIDTH-1:0] a,
                                                 input logic [WIDTH-1:0] b);
        logic [WIDTH:0] s;
        s       = {1'b0, a} + {1'b0, b};
        sat_add = s[WIDTH] ? {WIDTH{1'b1}} : s[WIDTH-1:0];
    endfunction

    // Correction step is one unit of the ninth decision's weight.
    localparam logic [WIDTH-1:0] CORR_STEP = bit_of(IW'(ssm_pkg::CORR_DECISION - 2));

    logic                   conversion_start_n_meta_reg;
    logic                   conversion_start_n_sync_reg;
    logic                   conversion_start_n_last_reg;
    logic                   sel_meta_reg;
    logic                   sel_sync_reg;
    ssm_pkg::ssm_dev_state_t state_reg;
    logic [IW-1:0]          dec_idx_reg;
    logic [TW-1:0]          tick_reg;
    logic                   check_done_reg;
    logic [WIDTH-1:0]       resolved_reg;
    logic [WIDTH-1:0]       resolved_next;
    logic [WIDTH-1:0]       trial_reg;
    logic [WIDTH-1:0]       trial_next;
    logic                   busy_reg;
    logic [WIDTH-1:0]       result_reg;
    logic                   result_valid_reg;
    logic                   sh_active_reg;
    logic [WIDTH-1:0]       sh_word_reg;
    logic [IW-1:0]          sh_bit_reg;
    logic [1:0]             sh_qtr_reg;
    logic [QW-1:0]          sh_tick_reg;
    logic                   sclk_reg;
    logic                   serial_result_out_reg;
    logic                   launch;
    logic                   is_corr;
    logic                   check_end;
    logic                   dec_end;
    logic                   last_dec;
    logic [TW-1:0]          dec_limit;
    logic                   qtr_end;

    // Pins come from the host's clock domain, so two flops before any use.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            conversion_start_n_meta_reg <= 1'b1;
            conversion_start_n_sync_reg <= 1'b1;
            conversion_start_n_last_reg <= 1'b1;
            sel_meta_reg  <= 1'b1;
            sel_sync_reg  <= 1'b1;
        end else begin
            conversion_start_n_meta_reg <= lnk.conversion_start_n;
            conversion_start_n_sync_reg <= conversion_start_n_meta_reg;
            conversion_start_n_last_reg <= conversion_start_n_sync_reg;
            sel_meta_reg  <= lnk.clock_source_select;
            sel_sync_reg  <= sel_meta_reg;
        end
    end

    // A falling start edge launches only from idle; the strobe may rise at any time.
    assign launch   = (state_reg == ssm_pkg::DEV_IDLE) && conversion_start_n_last_reg && !conversion_start_n_sync_reg;
    assign is_corr  = (dec_idx_reg == CORR_IDX);
    assign last_dec = (dec_idx_reg == LAST_IDX);
    // The tenth decision is split, so its decide half is shortened to keep timing.
    assign dec_limit = (is_corr && check_done_reg) ? TW'(DEC_CYC - CHECK_CYC - 1)
                                                   : TW'(DEC_CYC - 1);
    assign check_end = (state_reg == ssm_pkg::DEV_CONVERSION_START_N) && is_corr && !check_done_reg
                       && (tick_reg == TW'(CHECK_CYC - 1));
    assign dec_end   = (state_reg == ssm_pkg::DEV_CONVERSION_START_N) && !check_end
                       && (tick_reg == dec_limit);

    // Conversion sequencer.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_reg <= ssm_pkg::DEV_IDLE;
        end else begin
            case (state_reg)
                ssm_pkg::DEV_IDLE: begin
                    if (launch) begin
                        state_reg <= ssm_pkg::DEV_CONVERSION_START_N;
                    end
                end
                ssm_pkg::DEV_CONVERSION_START_N: begin
                    if (dec_end && last_dec) begin
                        state_reg <= ssm_pkg::DEV_IDLE;
                    end
                end
                default: begin
                    state_reg <= ssm_pkg::DEV_IDLE;
                end
            endcase
        end
    end

    // Decision index and timing within a decision.
    always_ff @(posedge i_clock) begin
        if (i_rst || launch) begin
            tick_reg       <= '0;
            dec_idx_reg    <= '0;
            check_done_reg <= 1'b0;
        end else if (check_end) begin
            tick_reg       <= '0;
            check_done_reg <= 1'b1;
        end else if (dec_end) begin
            tick_reg       <= '0;
            check_done_reg <= 1'b0;
            if (!last_dec) begin
                dec_idx_reg <= IW'(dec_idx_reg + 1'b1);
            end
        end else if (state_reg == ssm_pkg::DEV_CONVERSION_START_N) begin
            tick_reg <= TW'(tick_reg + 1'b1);
        end
    end

    // Resolved bits and the next trial value, decided at the end of each period.
    always_comb begin
        resolved_next = resolved_reg;
        trial_next    = trial_reg;
        if (launch) begin
            resolved_next = '0;
            trial_next    = bit_of('0);
        end else if (check_end) begin
            // Check value at or below the input: earlier bits came out one step low.
            if (!i_cmp_high) begin
                resolved_next = trial_reg;
            end
            trial_next = resolved_next | bit_of(dec_idx_reg);
        end else if (dec_end) begin
            if (!i_cmp_high) begin
                resolved_next = resolved_reg | bit_of(dec_idx_reg);
            end
            if (!last_dec) begin
                if (IW'(dec_idx_reg + 1'b1) == CORR_IDX) begin
                    trial_next = sat_add(resolved_next, CORR_STEP);
                end else begin
                    trial_next = resolved_next | bit_of(IW'(dec_idx_reg + 1'b1));
                end
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            resolved_reg <= '0;
            trial_reg    <= '0;
        end else begin
            resolved_reg <= resolved_next;
            trial_reg    <= trial_next;
        end
    end

    // Busy and the finished result.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            busy_reg         <= 1'b1;
            result_reg       <= ssm_pkg::RESULT_RST;
            result_valid_reg <= 1'b0;
        end else begin
            result_valid_reg <= 1'b0;
            if (launch) begin
                busy_reg <= 1'b0;
            end else if (dec_end && last_dec) begin
                busy_reg         <= 1'b1;
                result_reg       <= resolved_next;
                result_valid_reg <= 1'b1;
            end
        end
    end

    // Serial master. Each bit spends four quarters: low, high, high, low, so
    // data changing at the bit start is a quarter clear of both edges.
    assign qtr_end = (sh_tick_reg == QW'(QTR_CYC - 1));

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            sh_active_reg <= 1'b0;
            sh_word_reg   <= '0;
            sh_bit_reg    <= '0;
            sh_qtr_reg    <= 2'h0;
            sh_tick_reg   <= '0;
            sclk_reg      <= 1'b0;
            serial_result_out_reg     <= 1'b0;
        end else if (launch && (sel_sync_reg == ssm_pkg::MASTER_SEL)) begin
            // Previous result leaves while the new one is being decided.
            sh_active_reg <= 1'b1;
            sh_word_reg   <= result_reg;
            serial_result_out_reg     <= result_reg[WIDTH-1];
            sh_bit_reg    <= '0;
            sh_qtr_reg    <= 2'h0;
            sh_tick_reg   <= '0;
            sclk_reg      <= 1'b0;
        end else if (sh_active_reg) begin
            sh_tick_reg <= qtr_end ? '0 : QW'(sh_tick_reg + 1'b1);
            if (qtr_end) begin
                sh_qtr_reg <= 2'(sh_qtr_reg + 1'b1);
                sclk_reg   <= (sh_qtr_reg == 2'h0) || (sh_qtr_reg == 2'h1);
                if (sh_qtr_reg == 2'h3) begin
                    if (sh_bit_reg == LAST_IDX) begin
                        sh_active_reg <= 1'b0;
                    end else begin
                        sh_bit_reg  <= IW'(sh_bit_reg + 1'b1);
                        sh_word_reg <= {sh_word_reg[WIDTH-2:0], 1'b0};
                        serial_result_out_reg   <= sh_word_reg[WIDTH-2];
                    end
                end
            end
        end
    end

    // Host keeps quiet late in a conversion; nothing here guards against noise.
    assign lnk.busy              = busy_reg;
    assign lnk.serial_clock      = sclk_reg;
    assign lnk.serial_result_out = serial_result_out_reg;
    assign o_trial               = trial_reg;
    assign o_result              = result_reg;
    assign o_result_valid        = result_valid_reg;

endmodule

`default_nettype wire

//--- design/ssm_host_slave.sv
/*
 * Host end: starts conversions and receives each result as serial slave,
 * using the converter's busy pin as its slave select.
 * Assumes it is the only slave on the link and that the converter makes
 * the serial clock, which stands still outside a transfer.
 */
`timescale 1ns/1ps
`default_nettype none

module ssm_host_slave #(
    parameter int WIDTH     = ssm_pkg::RESULT_BITS,     // Transfer width.
    parameter int START_CYC = ssm_pkg::START_LOW_CYC,   // Start strobe low time.
    parameter int WAIT_CYC  = ssm_pkg::BUSY_WAIT_CYC    // Wait for busy to fall.
) (
    input  wire logic        i_clock,        // Host core clock.
    input  wire logic        i_rst,          // Synchronous reset, high.
    ssm_link_if.host         lnk,            // Pins toward the converter.
    input  wire logic        i_start,        // Request one conversion.
    output logic             o_ready,        // A request would be taken.
    output logic [WIDTH-1:0] o_word,         // Word received in last frame.
    output logic             o_word_valid,   // Pulse when o_word updates.
    output logic             o_no_answer     // Pulse when busy never fell.
);

    localparam int CW = $clog2(WAIT_CYC + START_CYC + 1);

    ssm_pkg::ssm_host_state_t state_reg;
    logic [CW-1:0]            cnt_reg;
    logic                     conversion_start_n_n_reg;
    logic                     sel_reg;
    logic                     ready_reg;
    logic                     busy_meta_reg;
    logic                     busy_sync_reg;
    logic                     busy_last_reg;
    logic [WIDTH-1:0]         link_shift_reg;
    logic [WIDTH-1:0]         word_reg;
    logic                     word_valid_reg;
    logic                     no_answer_reg;
    logic                     busy_fall;
    logic                     busy_rise;

    // Link side: sample each rising serial clock edge, most significant bit first.
    // No reset, since this clock only runs inside a frame.
    always_ff @(posedge lnk.serial_clock) begin
        link_shift_reg <= {link_shift_reg[WIDTH-2:0], lnk.serial_result_out};
    end

    // Busy is the slave select; it comes from another clock, so two flops first.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            busy_meta_reg <= 1'b1;
            busy_sync_reg <= 1'b1;
            busy_last_reg <= 1'b1;
        end else begin
            busy_meta_reg <= lnk.busy;
            busy_sync_reg <= busy_meta_reg;
            busy_last_reg <= busy_sync_reg;
        end
    end

    assign busy_fall = busy_last_reg && !busy_sync_reg;
    assign busy_rise = !busy_last_reg && busy_sync_reg;

    // The converter is always run as serial master.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            sel_reg <= ssm_pkg::MASTER_SEL;
        end else begin
            sel_reg <= ssm_pkg::MASTER_SEL;
        end
    end

    // Start sequencing. The strobe is raised early and nothing moves until busy rises.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_reg     <= ssm_pkg::HOST_IDLE;
            cnt_reg       <= '0;
            conversion_start_n_n_reg    <= 1'b1;
            ready_reg     <= 1'b1;
            no_answer_reg <= 1'b0;
        end else begin
            no_answer_reg <= 1'b0;
            case (state_reg)
                ssm_pkg::HOST_IDLE: begin
                    cnt_reg <= '0;
                    if (i_start) begin
                        conversion_start_n_n_reg <= 1'b0;
                        ready_reg  <= 1'b0;
                        state_reg  <= ssm_pkg::HOST_PULSE;
                    end
                end
                ssm_pkg::HOST_PULSE: begin
                    cnt_reg <= CW'(cnt_reg + 1'b1);
                    if (cnt_reg == CW'(START_CYC - 1)) begin
                        conversion_start_n_n_reg <= 1'b1;
                        state_reg  <= ssm_pkg::HOST_WAIT_LOW;
                    end
                end
                ssm_pkg::HOST_WAIT_LOW: begin
                    cnt_reg <= CW'(cnt_reg + 1'b1);
                    if (busy_fall || !busy_sync_reg) begin
                        state_reg <= ssm_pkg::HOST_WAIT_HIGH;
                    end else if (cnt_reg == CW'(START_CYC + WAIT_CYC - 1)) begin
                        no_answer_reg <= 1'b1;
                        ready_reg     <= 1'b1;
                        state_reg     <= ssm_pkg::HOST_IDLE;
                    end
                end
                ssm_pkg::HOST_WAIT_HIGH: begin
                    // Pins stay static until the conversion ends.
                    if (busy_rise) begin
                        ready_reg <= 1'b1;
                        state_reg <= ssm_pkg::HOST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ssm_pkg::HOST_IDLE;
                end
            endcase
        end
    end

    // The shifter stopped long before busy rises, so its word is stable to take here.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            word_reg       <= ssm_pkg::RESULT_RST;
            word_valid_reg <= 1'b0;
        end else begin
            word_valid_reg <= 1'b0;
            if (busy_rise && (state_reg == ssm_pkg::HOST_WAIT_HIGH)) begin
                word_reg       <= link_shift_reg;
                word_valid_reg <= 1'b1;
            end
        end
    end

    assign lnk.conversion_start_n  = conversion_start_n_n_reg;
    assign lnk.clock_source_select = sel_reg;
    assign o_ready                 = ready_reg;
    assign o_word                  = word_reg;
    assign o_word_valid            = word_valid_reg;
    assign o_no_answer             = no_answer_reg;

endmodule

`default_nettype wire

//--- verification/ssm_link_assertions.sv
/* Checker on the link pins between the converter and host ends.
   Assumes the converter clock and reset, and a quarter bit of two cycles. */
`timescale 1ns/1ps
`default_nettype none
module ssm_link_assertions #(
    parameter int DEC_CYC = 16  // Cycles per decision.
) (
    input wire logic i_clock,             // Converter clock.
    input wire logic i_rst,               // Converter reset.
    input wire logic conversion_start_n,  // Start pin.
    input wire logic clock_source_select, // Mode pin.
    input wire logic busy,                // Busy pin.
    input wire logic serial_clock,        // Serial clock pin.
    input wire logic serial_result_out    // Serial data pin.
);
    localparam int LO = 12 * DEC_CYC - 3;
    localparam int HI = 12 * DEC_CYC + 1;
    // Cycles from busy falling to the point 8 us in, scaled to the decision length.
    localparam logic [11:0] LATE = 12'((8000 * DEC_CYC) / ssm_pkg::DECISION_NS);
    logic [3:0]  edge_reg;
    logic [11:0] low_reg;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // Counters clear while busy is high, so each frame is judged alone.
    always_ff @(posedge i_clock) begin
        if (i_rst || busy) begin
            edge_reg <= 4'h0;
            low_reg  <= 12'h000;
        end else begin
            low_reg <= low_reg + 12'h001;
            if ($rose(serial_clock)) begin
                edge_reg <= edge_reg + 4'h1;
            end
        end
    end
    sequence s_launch;
        $fell(conversion_start_n) && busy;
    endsequence
    sequence s_hold;
        $stable(serial_result_out) [*5];
    endsequence
    busy_on_start_a: assert property (s_launch |-> ##[1:5] !busy)
        else $error("busy did not fall after start");
    sclk_start_a: assert property ($fell(busy) |-> !serial_clock ##[1:4] serial_clock)
        else $error("serial clock did not start");
    sclk_high_a: assert property ($rose(serial_clock) |-> serial_clock [*4] ##1 !serial_clock)
        else $error("serial clock high time wrong");
    data_hold_a: assert property ($rose(serial_clock) |-> s_hold)
        else $error("serial data moved near a clock edge");
    idle_low_a: assert property (busy |-> !serial_clock)
        else $error("serial clock not idle low");
    edge_max_a: assert property (edge_reg <= 4'hc)
        else $error("too many serial clocks");
    frame_len_a: assert property ($rose(busy) |-> edge_reg == 4'hc)
        else $error("frame not twelve clocks");
    conversion_start_n_len_a: assert property ($rose(busy) |-> low_reg >= LO && low_reg <= HI)
        else $error("conversion length wrong");
    master_sel_a: assert property (clock_source_select == 1'b0)
        else $error("mode pin not master");
    late_quiet_a: assert property (!busy && low_reg >= LATE
        |-> $stable(conversion_start_n) && $stable(clock_source_select))
        else $error("host pins moved late in a conversion");
    start_high_a: assert property (!busy && low_reg == LATE |-> conversion_start_n)
        else $error("start strobe still low late in a conversion");
endmodule
`default_nettype wire

//--- verification/sar_sequencer_serial_master_tb.sv
/* Bench joining host and converter ends, with a comparator model.
   Assumes shrunk timing parameters; the converter runs on the link clock. */
`timescale 1ns/1ps
`default_nettype none
module sar_sequencer_serial_master_tb;
    localparam int DEC = 16;
    logic        i_clock  = 1'b0;
    logic        link_clk = 1'b0;
    logic        i_rst    = 1'b1;
    logic        start    = 1'b0;
    logic        cmp_high;
    logic        ready;
    logic        word_valid;
    logic        result_valid;
    logic        no_answer;
    int          valid_cnt = 0;
    int          na_cnt = 0;
    int          convs = 0;
    logic [11:0] trial;
    logic [11:0] result;
    logic [11:0] word;
    logic [11:0] vin = 12'h000;
    logic [11:0] prev = 12'h000;
    logic [11:0] sh_reg = 12'h000;
    logic [7:0]  dcnt = 8'h00;
    int          win_lo = 999;
    int          win_hi = 0;
    int          edges = 0;
    int          cyc = 0;
    int          error_cnt = 0;
    int          samples_checked = 0;
    ssm_link_if lnk ();
    ssm_sar_device #(.DEC_CYC(DEC), .CHECK_CYC(8), .QTR_CYC(2)) u_ssm_sar_device (
        .i_clock(link_clk), .i_rst(i_rst), .lnk(lnk.dev), .o_trial(trial),
        .i_cmp_high(cmp_high), .o_result(result), .o_result_valid(result_valid));
    ssm_host_slave #(.START_CYC(60), .WAIT_CYC(200)) u_ssm_host_slave (
        .i_clock(i_clock), .i_rst(i_rst), .lnk(lnk.host), .i_start(start),
        .o_ready(ready), .o_word(word), .o_word_valid(word_valid), .o_no_answer(no_answer));
    ssm_link_assertions #(.DEC_CYC(DEC)) u_ssm_link_assertions (
        .i_clock(link_clk), .i_rst(i_rst), .conversion_start_n(lnk.conversion_start_n),
        .clock_source_select(lnk.clock_source_select), .busy(lnk.busy),
        .serial_clock(lnk.serial_clock), .serial_result_out(lnk.serial_result_out));
    // Clocks in unrelated phase.
    always #2.5 i_clock = ~i_clock;
    always #24 link_clk = ~link_clk;
    // Comparator; a window on the cycle count since busy fell flips one answer.
    assign cmp_high = (trial > vin) ^ (dcnt >= win_lo && dcnt <= win_hi);
    // Converter cycle count since busy fell and the bench's own view of the wire.
    always @(posedge link_clk) dcnt <= lnk.busy ? 8'h00 : dcnt + 8'h01;
    always @(posedge lnk.serial_clock) begin
        sh_reg <= {sh_reg[10:0], lnk.serial_result_out};
        edges  <= edges + 1;
    end
    // Flag pulses are counted on their rise, so the slow clock adds no lag.
    always @(posedge result_valid) valid_cnt++;
    always @(posedge no_answer) na_cnt++;
    // A hang counts as a mismatch.
    always @(posedge i_clock) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            give_verdict();
        end
    end
    task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One conversion; the frame carries the result of the one before.
    task automatic run_conversion_start_n(input logic [11:0] v, input int lo, input int hi,
                            input logic [11:0] exp_res);
        int n;
        n = 0;
        convs++;
        vin = v;
        win_lo = lo;
        win_hi = hi;
        edges = 0;
        while (ready !== 1'b1) begin
            @(posedge i_clock);
            #1;
        end
        start = 1'b1;
        @(posedge i_clock);
        #1 start = 1'b0;
        while (word_valid !== 1'b1 && n < 4000) begin
            @(posedge i_clock);
            #1 n++;
        end
        check("word valid", 12'h001, {11'h000, word_valid});
        check("result valid", 12'(convs), 12'(valid_cnt));
        check("no answer", 12'h000, 12'(na_cnt));
        check("host word", prev, word);
        check("wire word", prev, sh_reg);
        check("clock count", 12'h00c, 12'(edges));
        check("clock idle", 12'h000, {11'h000, lnk.serial_clock});
        check("result", exp_res, result);
        prev = exp_res;
    endtask
    task automatic test_codes();
        logic [11:0] tbl [5] = '{12'h000, 12'hfff, 12'h800, 12'h7ff, 12'ha5c};
        foreach (tbl[i]) run_conversion_start_n(tbl[i], 999, 0, tbl[i]);
    endtask
    task automatic test_correction();
        run_conversion_start_n(12'h0aa, 134, 147, 12'h0aa);
        run_conversion_start_n(12'h0aa, 166, 179, 12'h0a9);
    endtask
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge link_clk);
        @(posedge i_clock);
        #1 i_rst = 1'b0;
        test_codes();
        test_correction();
        give_verdict();
    end
endmodule
`default_nettype wire
